// file: verification/vrr_host_model.sv
// Host serial model: sends one 16-bit frame per request (mode 3, MSB first).
// Assumes i_go is raised between clock edges and dropped before the frame ends.
`timescale 1ns/1ps
module vrr_host_model #(
  parameter int HALF = 5
) (
  // Clock and request.
  input  wire logic        i_clk_sys,
  input  wire logic        i_go,
  input  wire logic [15:0] i_word,
  // Serial pins.
  input  wire logic        i_miso,
  output logic             o_sclk,
  output logic             o_cs_n,
  output logic             o_mosi,
  // Completion and the word shifted in.
  output logic             o_done,
  output logic [15:0]      o_rx
);
  // ---------------------------------------------------------------------------
  // Frame engine
  // ---------------------------------------------------------------------------
  // The serial clock idles high between frames. A half period of five clocks
  // leaves room for the pin synchronisers on the far side.
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
    o_done = 1'b0;
    o_rx   = 16'h0000;
    forever begin
      @(posedge i_clk_sys);
      if (i_go) begin
        @(negedge i_clk_sys);
        o_cs_n = 1'b0;
        for (int b = 15; b >= 0; b--) begin
          repeat (HALF) @(negedge i_clk_sys);
          o_sclk = 1'b0;
          o_mosi = i_word[b];
          repeat (HALF) @(negedge i_clk_sys);
          o_rx[b] = i_miso;
          o_sclk  = 1'b1;
        end
        repeat (HALF) @(negedge i_clk_sys);
        o_cs_n = 1'b1;
        o_mosi = ~o_mosi;  // A released line must not look like valid data.
        o_done = 1'b1;
        @(negedge i_clk_sys);
        o_done = 1'b0;
      end
    end
  end
endmodule

// file: verification/vrr_readout_test.sv
// Self-checking bench for the readout block: host frames, record stream, fetch.
// Assumes the host model file is compiled first; read answers lag one frame.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("[ERR] %0t exp %h got %h", $time, e, a); end end
module vrr_readout_test;
  logic clk, resetn, sclk, cs_n, mosi, miso, oe_n, last_m, smp_valid, smp_ready;
  logic rec_done, time_mode, rt_mode, fetch_req, rt_axis, signed_fmt, rt20, go, done;
  logic [3:0]  fetch_rec, exp_rec;
  logic [15:0] word, rx;
  logic [31:0] seed;
  logic [16:0] pend;
  int bad_count, cmp_count, cyc;
  vrr_pkg::vrr_sample_t smp_data;
  vrr_pkg::vrr_sample_t mem [512];
  vrr_pkg::vrr_header_t hdr;
  logic [16:0] q [$];
  logic [3:0]  fq [$];
  // ---------------------------------------------------------------------------
  // Clock, wire level and instances
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // With no pull on the line, an undriven output shows the inverse of its last bit.
  always @(posedge clk) if (!oe_n) last_m <= miso;
  vrr_readout vrr_readout_i (.i_clk_sys(clk), .i_resetn(resetn), .i_spi_sclk(sclk),
    .i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe_n(oe_n),
    .i_smp_valid(smp_valid), .i_smp_data(smp_data), .o_smp_ready(smp_ready),
    .i_rec_done(rec_done), .i_rec_hdr(hdr), .i_time_mode(time_mode), .i_realtime(rt_mode),
    .o_fetch_req(fetch_req), .o_fetch_rec(fetch_rec), .o_rt_axis(rt_axis),
    .o_signed_fmt(signed_fmt), .o_rt_range_20g(rt20));
  vrr_host_model vrr_host_model_i (.i_clk_sys(clk), .i_go(go), .i_word(word),
    .i_miso(oe_n ? ~last_m : miso), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
    .o_done(done), .o_rx(rx));
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic conclude();
    if (bad_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Each frame hands in the note for the previous frame's answer.
  task automatic xfer(input logic [15:0] w, input logic [15:0] e, input logic c);
    q.push_back(pend);
    pend = {c, e};
    @(negedge clk);
    go = 1'b1;
    word = w;
    @(negedge clk);
    go = 1'b0;
    do @(posedge clk); while (!done);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    xfer({1'b0, a, 8'h00}, e, 1'b1);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    xfer({1'b1, a, d}, 16'h0000, 1'b1);
  endtask
  // Streams n random samples, then closes the record with a random header.
  task automatic record(input int n);
    @(negedge clk);
    for (int k = 0; k < n; k++) begin
      seed = lfsr(seed);
      mem[k] = seed;
      smp_valid = 1'b1;
      smp_data = seed;
      while (!smp_ready) @(negedge clk);
      @(negedge clk);
    end
    smp_valid = 1'b0;
    repeat (4) @(negedge clk);
    repeat (6) begin
      seed = lfsr(seed);
      hdr = {hdr[143:0], seed};
    end
    rec_done = 1'b1;
    @(negedge clk);
    rec_done = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // ---------------------------------------------------------------------------
  // Result watcher and timeout
  // ---------------------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      conclude();
    end
    if (done) begin
      if (q.size() == 0) bad_count++;
      else if (q[0][16]) `CHK(rx, q[0][15:0])
      if (q.size() != 0) void'(q.pop_front());
    end
    if (fetch_req) begin
      if (fq.size() == 0) bad_count++;  // A refused command must not fetch.
      else begin
        exp_rec = fq.pop_front();
        `CHK(fetch_rec, exp_rec)
      end
    end
  end
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {resetn, smp_valid, rec_done, time_mode, rt_mode, go, cyc, bad_count, cmp_count} = '0;
    {word, smp_data, hdr, last_m} = '0;
    seed = 32'h222a250a;
    pend = 17'h00000;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    repeat (6) @(negedge clk);
    rd(vrr_pkg::OFS_X_PEAK, 16'h0000);
    rd(vrr_pkg::OFS_Y_BIN, 16'h0000);
    rd(vrr_pkg::OFS_SMP_PTR, 16'h0000);
    record(256);
    `CHK(signed_fmt, 1'b0)
    `CHK(rt20, 1'b0)
    rd(vrr_pkg::OFS_X_PEAK, hdr.peak_x);
    rd(vrr_pkg::OFS_Y_PEAK, hdr.peak_y);
    rd(vrr_pkg::OFS_X_BIN, {8'h00, hdr.bin_x});
    rd(vrr_pkg::OFS_Y_BIN, {8'h00, hdr.bin_y});
    rd(vrr_pkg::OFS_SMP_PTR, 16'h0000);
    rd(vrr_pkg::OFS_X_BUF, mem[0].x);
    rd(vrr_pkg::OFS_X_BUF, mem[1].x);
    rd(vrr_pkg::OFS_Y_BUF, mem[2].y);
    rd(vrr_pkg::OFS_SMP_PTR, 16'h0003);
    wr(7'h13, 8'h00);
    wr(vrr_pkg::OFS_SMP_PTR, 8'hff);
    rd(vrr_pkg::OFS_X_BUF, mem[255].x);
    rd(vrr_pkg::OFS_Y_BUF, mem[0].y);
    @(negedge clk) time_mode = 1'b1;
    record(512);
    `CHK(signed_fmt, 1'b1)
    wr(7'h13, 8'h01);
    wr(vrr_pkg::OFS_SMP_PTR, 8'hff);
    rd(vrr_pkg::OFS_X_BUF, mem[511].x);
    rd(vrr_pkg::OFS_X_BUF, mem[0].x);
    rd(vrr_pkg::OFS_SMP_PTR, 16'h0001);
    wr(vrr_pkg::OFS_REC_PTR, 8'h0a);
    fq.push_back(4'ha);
    wr(7'h37, 8'h20);
    wr(7'h37, 8'h20);
    rd(vrr_pkg::OFS_GLOB_CMD, 16'h2000);
    rd(vrr_pkg::OFS_REC_PTR, 16'h000a);
    record(4);
    rd(vrr_pkg::OFS_GLOB_CMD, 16'h0000);
    rd(vrr_pkg::OFS_X_PEAK, hdr.peak_x);
    rd(vrr_pkg::OFS_X_BUF, mem[0].x);
    wr(7'h37, 8'h04);
    rd(vrr_pkg::OFS_SMP_PTR, 16'h0000);
    // Real-time: a buffer read picks the channel and leaves the index alone.
    @(negedge clk) rt_mode = 1'b1;
    record(1);
    `CHK(rt20, 1'b1)
    rd(vrr_pkg::OFS_Y_BUF, mem[0].y);
    `CHK(rt_axis, 1'b1)
    rd(vrr_pkg::OFS_X_BUF, mem[0].x);
    `CHK(rt_axis, 1'b0)
    rd(vrr_pkg::OFS_SMP_PTR, 16'h0000);
    xfer(16'h0000, 16'h0000, 1'b0);
    repeat (4) @(negedge clk);
    conclude();
  end
endmodule

// file: verilog/vrr_pkg.sv
// Shared constants and carrier types for the vibration record readout block.
// Assumes a 50 MHz system clock and a 16-bit word host serial port.
package vrr_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets (byte addresses of the low byte of each word)
  // ---------------------------------------------------------------------------
  localparam logic [6:0] OFS_X_BUF     = 7'h06;
  localparam logic [6:0] OFS_Y_BUF     = 7'h08;
  localparam logic [6:0] OFS_TEMP      = 7'h0a;
  localparam logic [6:0] OFS_SUPPLY    = 7'h0c;
  localparam logic [6:0] OFS_SMP_PTR   = 7'h12;
  localparam logic [6:0] OFS_REC_PTR   = 7'h14;
  localparam logic [6:0] OFS_GLOB_CMD  = 7'h36;
  localparam logic [6:0] OFS_X_PEAK    = 7'h3c;
  localparam logic [6:0] OFS_Y_PEAK    = 7'h3e;
  localparam logic [6:0] OFS_TIME_LO   = 7'h40;
  localparam logic [6:0] OFS_TIME_HI   = 7'h42;
  localparam logic [6:0] OFS_X_BIN     = 7'h44;
  localparam logic [6:0] OFS_Y_BIN     = 7'h46;
  localparam logic [6:0] OFS_HDR_ONE   = 7'h4c;
  localparam logic [6:0] OFS_HDR_TWO   = 7'h4e;

  // ---------------------------------------------------------------------------
  // Record sizes, field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned TIME_LEN     = 512;
  localparam int unsigned FFT_LEN      = 256;
  localparam logic [8:0]  TIME_LAST    = 9'h1ff;
  localparam logic [8:0]  FFT_LAST     = 9'h0ff;
  localparam logic [8:0]  PTR_RESET    = 9'h000;
  localparam logic [3:0]  REC_RESET    = 4'h0;
  localparam logic [15:0] WORD_RESET   = 16'h0000;
  localparam int unsigned CMD_FETCH    = 13;
  localparam int unsigned CMD_PTR_ZERO = 10;
  localparam int unsigned SPI_WR_BIT   = 15;
  localparam logic [3:0]  SPI_LAST_BIT = 4'hf;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
  } vrr_sample_t;

  typedef struct packed {
    logic [15:0] peak_x;
    logic [15:0] peak_y;
    logic [7:0]  bin_x;
    logic [7:0]  bin_y;
    logic [15:0] time_lo;
    logic [15:0] time_hi;
    logic [15:0] info1;
    logic [15:0] info2;
    logic [15:0] temp;
    logic [15:0] supply;
  } vrr_header_t;

endpackage

// file: verilog/vrr_readout.sv
// Output-data readout register bank of a vibration sensor gateway.
// Assumes a host serial port (mode 3, 16-bit frames) on pins and a record source
// on the system clock that streams samples and a header per completed record.
`timescale 1ns/1ps
module vrr_readout (
  // Clock and reset.
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_resetn,
  // Host serial port pins.
  input  wire logic                 i_spi_sclk,
  input  wire logic                 i_spi_cs_n,
  input  wire logic                 i_spi_mosi,
  output logic                      o_spi_miso,
  output logic                      o_spi_miso_oe_n,
  // Record sample stream.
  input  wire logic                 i_smp_valid,
  input  wire vrr_pkg::vrr_sample_t i_smp_data,
  output logic                      o_smp_ready,
  // Record completion with its header.
  input  wire logic                 i_rec_done,
  input  wire vrr_pkg::vrr_header_t i_rec_hdr,
  // Mode settings from the recording control logic.
  input  wire logic                 i_time_mode,
  input  wire logic                 i_realtime,
  // Stored-record fetch request.
  output logic                      o_fetch_req,
  output logic [3:0]                o_fetch_rec,
  // Real-time channel select and data format indication.
  output logic                      o_rt_axis,
  output logic                      o_signed_fmt,
  output logic                      o_rt_range_20g
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]           sync1;
    logic [2:0]           sync2;
    logic                 sclk_q;
    logic [3:0]           bitcnt;
    logic [15:0]          rx;
    logic [15:0]          tx;
    logic                 miso;
    logic [8:0]           ptr;
    logic [8:0]           wr_idx;
    logic [3:0]           rec;
    logic                 cmd_fetch;
    logic                 fetch_req;
    logic                 load_pend;
    logic                 cap_pend;
    logic                 rt_axis;
    logic                 signed_fmt;
    vrr_pkg::vrr_sample_t buf_q;
    vrr_pkg::vrr_header_t hdr;
  } vrr_state_t;

  vrr_state_t           st;
  vrr_state_t           next_st;
  vrr_pkg::vrr_sample_t fifo_data;
  vrr_pkg::vrr_sample_t rd_data;
  logic                 fifo_valid;
  logic                 mem_wr;
  logic [8:0]           mem_wr_idx;
  logic [8:0]           last_idx;
  logic                 cs_n;
  logic                 sclk;
  logic                 mosi;
  logic                 sclk_rise;
  logic                 sclk_fall;
  logic                 frame_stb;
  logic [15:0]          frame;
  logic                 wr_stb;
  logic                 rd_stb;
  logic [6:0]           word_addr;
  logic [15:0]          rdata;
  logic                 buf_read;
  logic                 ptr_step;

  // ---------------------------------------------------------------------------
  // Serial port decoding
  // ---------------------------------------------------------------------------

  // Only the second synchroniser stage is looked at by the edge detector.
  assign cs_n      = st.sync2[2];
  assign sclk      = st.sync2[1];
  assign mosi      = st.sync2[0];
  assign sclk_rise = !cs_n && sclk && !st.sclk_q;
  assign sclk_fall = !cs_n && !sclk && st.sclk_q;
  assign frame_stb = sclk_rise && (st.bitcnt == vrr_pkg::SPI_LAST_BIT);
  assign frame     = {st.rx[14:0], mosi};
  assign wr_stb    = frame_stb && frame[vrr_pkg::SPI_WR_BIT];
  assign rd_stb    = frame_stb && !frame[vrr_pkg::SPI_WR_BIT];
  assign word_addr = {frame[14:9], 1'b0};

  // Outside real-time mode, a read of either axis buffer is what moves the index along.
  assign buf_read = rd_stb && ((word_addr == vrr_pkg::OFS_X_BUF) ||
                               (word_addr == vrr_pkg::OFS_Y_BUF));

  // The last valid index depends on the record kind.
  assign last_idx = i_time_mode ? vrr_pkg::TIME_LAST : vrr_pkg::FFT_LAST;

  // Real-time reads only pick a channel and do not walk the record.
  assign ptr_step = buf_read && !i_realtime;

  // Read data multiplexer; unused upper bits and unmapped words read as zero.
  always_comb begin
    rdata = vrr_pkg::WORD_RESET;
    case (word_addr)
      vrr_pkg::OFS_X_BUF:    rdata = st.buf_q.x;
      vrr_pkg::OFS_Y_BUF:    rdata = st.buf_q.y;
      vrr_pkg::OFS_TEMP:     rdata = st.hdr.temp;
      vrr_pkg::OFS_SUPPLY:   rdata = st.hdr.supply;
      vrr_pkg::OFS_SMP_PTR:  rdata = {7'h00, st.ptr};
      vrr_pkg::OFS_REC_PTR:  rdata = {12'h000, st.rec};
      vrr_pkg::OFS_GLOB_CMD: rdata = 16'(st.cmd_fetch) << vrr_pkg::CMD_FETCH;
      vrr_pkg::OFS_X_PEAK:   rdata = st.hdr.peak_x;
      vrr_pkg::OFS_Y_PEAK:   rdata = st.hdr.peak_y;
      vrr_pkg::OFS_TIME_LO:  rdata = st.hdr.time_lo;
      vrr_pkg::OFS_TIME_HI:  rdata = st.hdr.time_hi;
      vrr_pkg::OFS_X_BIN:    rdata = {8'h00, st.hdr.bin_x};
      vrr_pkg::OFS_Y_BIN:    rdata = {8'h00, st.hdr.bin_y};
      vrr_pkg::OFS_HDR_ONE:  rdata = st.hdr.info1;
      vrr_pkg::OFS_HDR_TWO:  rdata = st.hdr.info2;
      default:               rdata = vrr_pkg::WORD_RESET;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Sample stream into the store
  // ---------------------------------------------------------------------------

  // Store reads win over writes, so the buffer drain stalls during a reload and
  // the stall reaches the source through the buffer's ready.
  assign mem_wr     = fifo_valid && !st.load_pend;
  assign mem_wr_idx = i_realtime ? vrr_pkg::PTR_RESET : st.wr_idx;

  vrr_skid_fifo #(
    .W     ($bits(vrr_pkg::vrr_sample_t)),
    .DEPTH (2)
  ) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_resetn    (i_resetn),
    .i_in_valid  (i_smp_valid),
    .i_in_data   (i_smp_data),
    .o_in_ready  (o_smp_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (!st.load_pend)
  );

  vrr_sample_store u_store (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_wr_en   (mem_wr),
    .i_wr_idx  (mem_wr_idx),
    .i_wr_data (fifo_data),
    .i_rd_en   (st.load_pend),
    .i_rd_idx  (i_realtime ? vrr_pkg::PTR_RESET : st.ptr), // Real-time data sits in slot zero.
    .o_rd_data (rd_data)
  );

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    next_st = st;

    // Two-stage synchroniser for the port pins.
    next_st.sync1  = {i_spi_cs_n, i_spi_sclk, i_spi_mosi};
    next_st.sync2  = st.sync1;
    next_st.sclk_q = sclk;

    // Shift in on rising edges, drive out on falling edges.
    if (cs_n) begin
      next_st.bitcnt = 4'h0;
    end else if (sclk_rise) begin
      next_st.rx     = frame;
      next_st.bitcnt = 4'(st.bitcnt + 4'h1);
    end
    if (sclk_fall) begin
      next_st.miso = st.tx[15];
      next_st.tx   = {st.tx[14:0], 1'b0};
    end
    // The answer to a read goes out during the following frame.
    if (frame_stb) begin
      next_st.tx = wr_stb ? vrr_pkg::WORD_RESET : rdata;
    end

    // Stage the store read and capture its data a cycle later.
    next_st.load_pend = 1'b0;
    next_st.cap_pend  = st.load_pend;
    next_st.fetch_req = 1'b0;
    if (st.cap_pend) begin
      next_st.buf_q = rd_data;
    end

    // Writes land in the low or high byte of the addressed word.
    if (wr_stb) begin
      case (frame[14:8])
        vrr_pkg::OFS_SMP_PTR: begin
          next_st.ptr[7:0]  = frame[7:0];
          next_st.load_pend = 1'b1;
        end
        vrr_pkg::OFS_SMP_PTR + 7'h01: begin
          next_st.ptr[8]    = frame[0];
          next_st.load_pend = 1'b1;
        end
        vrr_pkg::OFS_REC_PTR: begin
          next_st.rec = frame[3:0];
        end
        vrr_pkg::OFS_GLOB_CMD + 7'h01: begin
          if (frame[vrr_pkg::CMD_PTR_ZERO-8]) begin
            next_st.ptr       = vrr_pkg::PTR_RESET;
            next_st.load_pend = 1'b1;
          end
          if (frame[vrr_pkg::CMD_FETCH-8] && !st.cmd_fetch) begin
            next_st.cmd_fetch = 1'b1;
            next_st.fetch_req = 1'b1;
            next_st.wr_idx    = vrr_pkg::PTR_RESET;
          end
        end
        default: begin
        end
      endcase
    end

    // Outside real-time mode, buffer reads walk the record and wrap after its last sample.
    if (ptr_step) begin
      next_st.ptr       = (st.ptr >= last_idx) ? vrr_pkg::PTR_RESET
                                               : 9'(st.ptr + 9'h001);
      next_st.load_pend = 1'b1;
    end
    if (buf_read && i_realtime) begin
      next_st.rt_axis = (word_addr == vrr_pkg::OFS_Y_BUF);
    end

    // Outside real-time mode, each accepted sample goes to the next store slot.
    if (mem_wr) begin
      next_st.wr_idx = (st.wr_idx >= last_idx) ? vrr_pkg::PTR_RESET
                                               : 9'(st.wr_idx + 9'h001);
      if (i_realtime) begin
        next_st.load_pend = 1'b1;
      end
    end

    // A finished record resets the index and shows its first samples.
    if (i_rec_done) begin
      next_st.hdr        = i_rec_hdr;
      next_st.ptr        = vrr_pkg::PTR_RESET;
      next_st.wr_idx     = vrr_pkg::PTR_RESET;
      next_st.load_pend  = 1'b1;
      // A fetch written in this very cycle wins over the clear, so it is not lost.
      next_st.cmd_fetch  = next_st.fetch_req;
      next_st.signed_fmt = i_time_mode || i_realtime;
    end
  end

  // ---------------------------------------------------------------------------
  // State register and outputs
  // ---------------------------------------------------------------------------

  // Reset puts every header word and both pointers at zero.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st       <= '0;
      st.sync1 <= 3'h6;
      st.sync2 <= 3'h6;
      st.sclk_q <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // The output driver is enabled only while the host selects the device.
  assign o_spi_miso      = st.miso;
  assign o_spi_miso_oe_n = cs_n;
  assign o_fetch_req     = st.fetch_req;
  assign o_fetch_rec     = st.rec;
  assign o_rt_axis       = st.rt_axis;
  assign o_signed_fmt    = st.signed_fmt;
  assign o_rt_range_20g  = i_realtime;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_peak_capture: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    i_rec_done |=> (st.hdr.peak_x == $past(i_rec_hdr.peak_x)) &&
                   (st.hdr.peak_y == $past(i_rec_hdr.peak_y)))
    else $error("Peak registers did not take the record header.");

  a_bin_upper_zero: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (rd_stb && (word_addr == vrr_pkg::OFS_X_BIN)) |=> (st.tx[15:8] == 8'h00))
    else $error("Bin register upper byte is not zero.");

  a_ptr_range: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (rd_stb && (word_addr == vrr_pkg::OFS_SMP_PTR))
    |=> (st.tx == {7'h00, $past(st.ptr)}))
    else $error("Index read did not return the nine-bit field.");

  a_done_clears_ptr: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    i_rec_done |=> (st.ptr == vrr_pkg::PTR_RESET) ##2 (st.buf_q == $past(rd_data)))
    else $error("Record completion did not reload sample zero.");

  a_ptr_advance: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (ptr_step && !i_rec_done && (st.ptr < last_idx)) |=> (st.ptr == $past(st.ptr) + 9'h001))
    else $error("Buffer read did not advance the index.");

  a_ptr_wrap: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (ptr_step && !i_rec_done && (st.ptr == last_idx)) |=> (st.ptr == vrr_pkg::PTR_RESET))
    else $error("Index did not wrap after the last sample.");

  a_ptr_write_load: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (wr_stb && (frame[14:8] == vrr_pkg::OFS_SMP_PTR) && !i_rec_done && !ptr_step)
    |=> st.load_pend ##1 st.cap_pend ##1 (st.buf_q == $past(rd_data)))
    else $error("Index write did not load the buffers.");

  a_fetch_start: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (wr_stb && (frame[14:8] == vrr_pkg::OFS_GLOB_CMD + 7'h01) &&
     frame[vrr_pkg::CMD_FETCH-8] && !st.cmd_fetch && !i_rec_done)
    |=> (o_fetch_req && st.cmd_fetch && (o_fetch_rec == st.rec)) ##1 !o_fetch_req)
    else $error("Fetch command did not raise a one-cycle request.");

  a_fetch_self_clear: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (st.cmd_fetch && i_rec_done) |=> !st.cmd_fetch)
    else $error("Fetch command bit did not clear at completion.");

endmodule

// file: verilog/vrr_sample_store.sv
// Sample store: one record of paired axis samples held in flip-flops.
// Assumes the caller never asks for a read and a write in the same cycle.
`timescale 1ns/1ps
module vrr_sample_store (
  // Clock and reset.
  input  wire logic                i_clk_sys,
  input  wire logic                i_resetn,
  // Write port.
  input  wire logic                i_wr_en,
  input  wire logic [8:0]          i_wr_idx,
  input  wire vrr_pkg::vrr_sample_t i_wr_data,
  // Read port, data one cycle after the request.
  input  wire logic                i_rd_en,
  input  wire logic [8:0]          i_rd_idx,
  output vrr_pkg::vrr_sample_t     o_rd_data
);

  typedef struct packed {
    vrr_pkg::vrr_sample_t [vrr_pkg::TIME_LEN-1:0] mem;
    vrr_pkg::vrr_sample_t                         rd;
  } vrr_store_state_t;

  vrr_store_state_t st;
  vrr_store_state_t next_st;

  assign o_rd_data = st.rd;

  // A registered read keeps the wide multiplexer off the serial output path.
  always_comb begin
    next_st = st;
    if (i_wr_en) begin
      next_st.mem[i_wr_idx] = i_wr_data;
    end
    if (i_rd_en) begin
      next_st.rd = st.mem[i_rd_idx];
    end
  end

  // State register.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// file: verilog/vrr_skid_fifo.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides run on the system clock.
`timescale 1ns/1ps
module vrr_skid_fifo #(
  parameter int unsigned W     = 32,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset.
  input  wire logic         i_clk_sys,
  input  wire logic         i_resetn,
  // Filling side.
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // Draining side.
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] slot;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } vrr_fifo_state_t;

  vrr_fifo_state_t st;
  vrr_fifo_state_t next_st;
  logic            push;
  logic            pop;

  // Full and empty come straight from the occupancy count.
  assign o_in_ready  = (st.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (st.cnt != '0);
  assign o_out_data  = st.slot[st.rp];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Pointers wrap at the depth, so any depth works, not just powers of two.
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.slot[st.wp] = i_in_data;
      next_st.wp = (st.wp == AW'(DEPTH-1)) ? '0 : AW'(st.wp + AW'(1));
    end
    if (pop) begin
      next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : AW'(st.rp + AW'(1));
    end
    next_st.cnt = (AW+1)'(st.cnt + (AW+1)'(push) - (AW+1)'(pop));
  end

  // State register.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule
